// ==== adc_frame_fifo.v ====
// frame fifo holding complete readout frames between conversion and shifter
module adc_frame_fifo #(
  parameter WIDTH = 152,
  parameter DEPTH = 8,
  parameter PW    = 3
) (
  input  wire             clock_in,
  input  wire             rst_in,
  input  wire             clk_en_in,
  input  wire             wr_valid_in,
  output wire             wr_ready_out,
  input  wire [WIDTH-1:0] wr_data_in,
  output wire             rd_valid_out,
  input  wire             rd_ready_in,
  output wire [WIDTH-1:0] rd_data_out
);
  reg [WIDTH-1:0] mem [0:DEPTH-1]; // frame storage
  reg [PW-1:0]    wptr_reg;        // write pointer
  reg [PW-1:0]    rptr_reg;        // read pointer
  reg [PW:0]      count_reg;       // fill level

  assign wr_ready_out = (count_reg != DEPTH);
  assign rd_valid_out = (count_reg != 0);
  assign rd_data_out  = mem[rptr_reg];

  // pointer and level update
  always @(posedge clock_in) begin
    if (rst_in) begin
      wptr_reg  <= {PW{1'b0}};
      rptr_reg  <= {PW{1'b0}};
      count_reg <= {(PW+1){1'b0}};
    end else if (clk_en_in) begin
      if (wr_valid_in && wr_ready_out) begin
        mem[wptr_reg] <= wr_data_in;
        wptr_reg      <= wptr_reg + 1'b1;
      end
      if (rd_valid_out && rd_ready_in)
        rptr_reg <= rptr_reg + 1'b1;
      case ({wr_valid_in && wr_ready_out, rd_valid_out && rd_ready_in})
        2'b10:   count_reg <= count_reg + 1'b1;
        2'b01:   count_reg <= count_reg - 1'b1;
        default: count_reg <= count_reg;
      endcase
    end
  end
endmodule // adc_frame_fifo

// ==== adc_readout_monitor.sv ====
// checker for the serial readout port, sees top-level ports only
module adc_readout_monitor (
  input wire       clock_in,
  input wire       rst_in,
  input wire       clk_en_in,
  input wire       chip_select_n_in,
  input wire       sclk_in,
  input wire       conv_done_in,
  input wire       data_ready_n_out,
  input wire       dout_oe_out,
  input wire [3:0] pin_direction_bits_in,
  input wire [3:0] pin_level_write_in,
  input wire       pin_level_wr_in,
  input wire [3:0] gpio_pin_in,
  input wire [3:0] gpio_out,
  input wire [3:0] gpio_oe_out,
  input wire [3:0] pin_level_bits_out,
  input wire       frame_overflow_out,
  input wire       cmd_valid_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // ----------------------------------------------------------------
  // one domain: default clock and reset
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  // status capture leads the falling data-ready by two cycles
  ready_fall_a: assert property (conv_done_in && clk_en_in |-> ##3 !data_ready_n_out)
    else $error("data ready did not fall three cycles after done");
  ready_cause_a: assert property ($fell(data_ready_n_out) |-> $past(conv_done_in, 3))
    else $error("data ready fell without a conversion");
  // sync chain: allow a few cycles before the pin is released
  deselect_hiz_a: assert property ((chip_select_n_in && clk_en_in) [*4] |-> !dout_oe_out)
    else $error("data out driven while deselected");
  select_drive_a: assert property ((!chip_select_n_in && clk_en_in) [*6] |-> dout_oe_out)
    else $error("data out not driven while selected");
  // no new conversion near the edge, so the clear must show
  ready_clear_a: assert property (!conv_done_in [*3] ##0 $fell(sclk_in) ##1 !conv_done_in [*6]
    |-> data_ready_n_out)
    else $error("data ready not released by falling serial clock");
  input_pins_a: assert property ($stable(pin_direction_bits_in)
    |-> (gpio_oe_out & pin_direction_bits_in) == 4'h0)
    else $error("input pin is being driven");
  gpio_write_a: assert property (pin_level_wr_in |=> gpio_out ==
    (($past(pin_level_write_in) & ~$past(pin_direction_bits_in)) | ($past(gpio_out) & $past(pin_direction_bits_in))))
    else $error("pin write landed on the wrong pins");
  level_sync_a: assert property (!$past(rst_in, 1) && !$past(rst_in, 2) && !$past(rst_in, 3)
    |-> pin_level_bits_out == $past(gpio_pin_in, 3))
    else $error("pin levels do not follow the pads");
  // main scenarios reached
  cover property (conv_done_in);
  cover property ($fell(dout_oe_out));
  cover property ($rose(frame_overflow_out));
  cover property (cmd_valid_out);
endmodule // adc_readout_monitor

// ==== adc_readout_regs.vh ====
// constants for the serial readout port of the multichannel converter
`ifndef ADC_READOUT_REGS_VH
`define ADC_READOUT_REGS_VH
// ----------------------------------------------------------------
// frame layout
// ----------------------------------------------------------------
`define FRAME_BITS        152
`define STATUS_BITS       24
`define CHAN_BITS         16
`define CHAN_COUNT        8
`define STATUS_PATTERN    4'hC
`define FRAME_CNT_W       8
// ----------------------------------------------------------------
// timing, in conversion-clock periods; then pin count and fifo sizes
// ----------------------------------------------------------------
`define CAPTURE_LEAD_CLKS 2
`define GPIO_COUNT        4
`define FIFO_DEPTH        8
`define FIFO_PTR_W        3
`endif

// ==== adc_serial_readout_port.v ====
// serial readout port: framing, shifting, data-ready and general-purpose pins
`include "adc_readout_regs.vh"

// Operation
// - deselect resets port, tristates data out
// - data ready falls on conversion done
// - incomplete clocks cleared only by deselect
// - data in sampled on falling clock
// - data out changes on rising clock
// - continuous mode flags new data on output
// - continuous and on-demand readout supported
// - first falling clock returns data ready high
// - frame: 24 status, eight 16-bit words
// - status starts 1100, lead-off, pin bits
// - powered-down channel slots read zero
// - status captured two clocks before ready
// - chain enable repeats frame on extra clocks
// - on-demand frame stays intact while shifting
// - four pins, inputs after reset
// - level reads pins; writes drive outputs only
// - pins shared with pace and respiration
module adc_serial_readout_port (
  input  wire         clock_in,                // conversion clock domain
  input  wire         rst_in,                  // synchronous, active high
  input  wire         clk_en_in,               // freezes all state when low
  input  wire         chip_select_n_in,        // serial select, active low
  input  wire         sclk_in,                 // serial clock from host
  input  wire         din_in,                  // serial data from host
  output reg          dout_out,                // serial data to host
  output reg          dout_oe_out,             // data out driven when high
  output reg          data_ready_n_out,        // active-low data ready
  input  wire         conv_done_in,            // one-cycle conversion done pulse
  input  wire [127:0] chan_data_in,            // eight channel words, ch1 high
  input  wire [7:0]   chan_powered_in,         // per-channel power, bit0 = ch1
  input  wire [7:0]   lead_off_pos_status_in,  // positive lead-off bits
  input  wire [7:0]   lead_off_neg_status_in,  // negative lead-off bits
  input  wire         read_continuous_cmd_in,  // continuous readout mode
  input  wire         read_once_in,            // one-cycle on-demand read request
  input  wire         chain_enable_in,         // repeated readback enable
  input  wire [3:0]   pin_direction_bits_in,   // 1 = input, per pin
  input  wire [3:0]   pin_level_write_in,      // written pin levels
  input  wire         pin_level_wr_in,         // one-cycle write strobe
  output reg  [3:0]   pin_level_bits_out,      // sampled pin levels
  input  wire [3:0]   gpio_pin_in,             // pin levels from pads
  output reg  [3:0]   gpio_out,                // pin drive values
  output reg  [3:0]   gpio_oe_out,             // pin drive enables
  output reg          pace_input_out,          // alt function, pin one
  output reg          respiration_blanking_out,// alt function, pin two
  output reg          respiration_signal_out,  // alt function, pin three
  output reg          respiration_phase_out,   // alt function, pin four
  output reg          frame_overflow_out,      // fifo refused a frame
  output reg  [7:0]   cmd_byte_out,            // last received byte
  output reg          cmd_valid_out            // one-cycle byte strobe
);
  // ----------------------------------------------------------------
  // state machine codes
  // ----------------------------------------------------------------
  localparam ST_IDLE  = 2'b00; // waiting for a frame to load
  localparam ST_SHIFT = 2'b01; // frame loaded, shifting out
  localparam ST_DONE  = 2'b10; // frame exhausted, outputs zero

  // ----------------------------------------------------------------
  // synchronisers for link signals and pin pads
  // ----------------------------------------------------------------
  reg [1:0] cs_sync_reg;    // select, two stages
  reg [1:0] sclk_sync_reg;  // serial clock, two stages
  reg [1:0] din_sync_reg;   // data in, two stages
  reg [3:0] pin_s1_reg;     // pin first stage
  reg [3:0] pin_s2_reg;     // pin second stage
  reg       sclk_prev_reg;  // last synchronised clock, for edges

  wire cs_active = ~cs_sync_reg[1];
  wire sclk_rise = cs_active & sclk_sync_reg[1] & ~sclk_prev_reg;
  wire sclk_fall = cs_active & ~sclk_sync_reg[1] & sclk_prev_reg;
  // ready pulls high on any falling edge, even with select high
  wire sclk_fall_any = ~sclk_sync_reg[1] & sclk_prev_reg;

  // two-flop sampling of the link signals and the pin pads
  always @(posedge clock_in) begin
    if (rst_in) begin
      cs_sync_reg   <= 2'b11;
      sclk_sync_reg <= 2'b00;
      din_sync_reg  <= 2'b00;
      pin_s1_reg    <= 4'h0;
      pin_s2_reg    <= 4'h0;
      sclk_prev_reg <= 1'b0;
    end else if (clk_en_in) begin
      cs_sync_reg   <= {cs_sync_reg[0], chip_select_n_in};
      sclk_sync_reg <= {sclk_sync_reg[0], sclk_in};
      din_sync_reg  <= {din_sync_reg[0], din_in};
      pin_s1_reg    <= gpio_pin_in;
      pin_s2_reg    <= pin_s1_reg;
      sclk_prev_reg <= sclk_sync_reg[1];
    end
  end

  // ----------------------------------------------------------------
  // frame assembly
  // ----------------------------------------------------------------
  // zero a powered-down slot, slot order never changes
  function [127:0] mask_channels;
    input [127:0] data;
    input [7:0]   pwr;
    integer k;
    begin
      mask_channels = data;
      for (k = 0; k < `CHAN_COUNT; k = k + 1)
        if (!pwr[k])
          mask_channels[127-16*k -: 16] = 16'h0000;
    end
  endfunction

  reg [23:0] status_word_reg;  // status captured ahead of ready
  reg [1:0]  lead_cnt_reg;     // delay from capture to ready
  reg        lead_busy_reg;    // capture done, ready pending
  localparam [31:0] LEAD_LOAD = `CAPTURE_LEAD_CLKS - 1; // lead counter start

  // status is taken at the done pulse, ready falls two clocks later
  always @(posedge clock_in) begin
    if (rst_in) begin
      status_word_reg <= 24'h000000;
      lead_cnt_reg    <= 2'b00;
      lead_busy_reg   <= 1'b0;
    end else if (clk_en_in) begin
      if (conv_done_in) begin
        status_word_reg <= {`STATUS_PATTERN, lead_off_pos_status_in,
                            lead_off_neg_status_in, pin_s2_reg};
        lead_cnt_reg    <= LEAD_LOAD[1:0];
        lead_busy_reg   <= 1'b1;
      end else if (lead_busy_reg) begin
        if (lead_cnt_reg == 2'b00)
          lead_busy_reg <= 1'b0;
        lead_cnt_reg <= lead_cnt_reg - 2'd1;
      end
    end
  end

  // ready event fires the cycle the lead counter expires
  wire ready_event = lead_busy_reg & (lead_cnt_reg == 2'b00);
  reg [127:0] chan_hold_reg; // channel words, taken with status
  always @(posedge clock_in) begin
    if (rst_in)
      chan_hold_reg <= 128'h0;
    else if (clk_en_in && conv_done_in)
      chan_hold_reg <= mask_channels(chan_data_in, chan_powered_in);
  end

  // ----------------------------------------------------------------
  // frame fifo between conversion and shifter
  // ----------------------------------------------------------------
  wire                   fifo_wr_ready;
  wire                   fifo_rd_valid;
  wire [`FRAME_BITS-1:0] fifo_rd_data;
  reg                    fifo_pop;
  adc_frame_fifo #(
    .WIDTH (`FRAME_BITS),
    .DEPTH (`FIFO_DEPTH),
    .PW    (`FIFO_PTR_W)
  ) u_fifo (
    .clock_in     (clock_in),
    .rst_in       (rst_in),
    .clk_en_in    (clk_en_in),
    .wr_valid_in  (ready_event),
    .wr_ready_out (fifo_wr_ready),
    .wr_data_in   ({status_word_reg, chan_hold_reg}),
    .rd_valid_out (fifo_rd_valid),
    .rd_ready_in  (fifo_pop),
    .rd_data_out  (fifo_rd_data)
  );

  // ----------------------------------------------------------------
  // serial shifter
  // ----------------------------------------------------------------
  reg [1:0]             state_reg;   // shifter state
  reg [`FRAME_BITS-1:0] shift_reg;   // frame being shifted
  reg [`FRAME_BITS-1:0] frame_reg;   // copy for repeated readback
  reg [7:0]             bit_cnt_reg; // bits shifted this frame
  reg [7:0]             cmd_sh_reg;  // incoming command bits
  reg [2:0]             cmd_cnt_reg; // command bit count
  reg                   load_req_reg;// on-demand read pending

  // pop only when the shifter can accept a frame; the fifo may
  // then fill while the host is slow, which shows as overflow
  always @* begin
    fifo_pop = 1'b0;
    if (cs_active && fifo_rd_valid && state_reg != ST_SHIFT &&
        (read_continuous_cmd_in || load_req_reg))
      fifo_pop = 1'b1;
  end

  // shifter, command receiver and output pin
  always @(posedge clock_in) begin
    if (rst_in) begin
      state_reg     <= ST_IDLE;
      shift_reg     <= {`FRAME_BITS{1'b0}};
      frame_reg     <= {`FRAME_BITS{1'b0}};
      bit_cnt_reg   <= 8'h00;
      cmd_sh_reg    <= 8'h00;
      cmd_cnt_reg   <= 3'h0;
      load_req_reg  <= 1'b0;
      dout_out      <= 1'b0;
      dout_oe_out   <= 1'b0;
      cmd_byte_out  <= 8'h00;
      cmd_valid_out <= 1'b0;
    end else if (clk_en_in) begin
      cmd_valid_out <= 1'b0;
      if (read_once_in)
        load_req_reg <= 1'b1;
      if (!cs_active) begin
        // deselect clears any half-done command or frame
        state_reg   <= ST_IDLE;
        bit_cnt_reg <= 8'h00;
        cmd_cnt_reg <= 3'h0;
        dout_oe_out <= 1'b0;
        dout_out    <= 1'b0;
      end else begin
        dout_oe_out <= 1'b1;
        if (fifo_pop) begin
          // whole frame loaded at once, later conversions wait
          shift_reg    <= fifo_rd_data;
          frame_reg    <= fifo_rd_data;
          bit_cnt_reg  <= 8'h00;
          state_reg    <= ST_SHIFT;
          // a fresh request in the same cycle must not be lost
          load_req_reg <= read_once_in;
          // low on the output tells a continuous host that data waits
          dout_out     <= 1'b0;
        end else if (state_reg == ST_IDLE)
          dout_out <= 1'b1;
        if (sclk_rise) begin
          case (state_reg)
            ST_SHIFT: begin
              dout_out    <= shift_reg[`FRAME_BITS-1];
              shift_reg   <= {shift_reg[`FRAME_BITS-2:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 8'h01;
              if (bit_cnt_reg == `FRAME_BITS - 1) begin
                if (chain_enable_in) begin
                  shift_reg   <= frame_reg;
                  bit_cnt_reg <= 8'h00;
                end else
                  state_reg <= ST_DONE;
              end
            end
            ST_DONE: dout_out <= 1'b0;
            default: dout_out <= dout_out;
          endcase
        end
        if (sclk_fall) begin
          cmd_sh_reg  <= {cmd_sh_reg[6:0], din_sync_reg[1]};
          cmd_cnt_reg <= cmd_cnt_reg + 3'h1;
          if (cmd_cnt_reg == 3'h7) begin
            cmd_byte_out  <= {cmd_sh_reg[6:0], din_sync_reg[1]};
            cmd_valid_out <= 1'b1;
          end
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // data ready pin and overflow flag
  // ----------------------------------------------------------------
  // ready falls on any conversion event whatever the select level
  always @(posedge clock_in) begin
    if (rst_in) begin
      data_ready_n_out   <= 1'b1;
      frame_overflow_out <= 1'b0;
    end else if (clk_en_in) begin
      if (ready_event)
        data_ready_n_out <= 1'b0;
      else if (sclk_fall_any)
        data_ready_n_out <= 1'b1;
      if (ready_event && !fifo_wr_ready)
        frame_overflow_out <= 1'b1;
      else if (fifo_pop)
        frame_overflow_out <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // general-purpose pins
  // ----------------------------------------------------------------
  // per-pin drive, written level kept only for output pins
  genvar g;
  generate
    for (g = 0; g < `GPIO_COUNT; g = g + 1) begin : gen_pin
      always @(posedge clock_in) begin
        if (rst_in) begin
          gpio_out[g]    <= 1'b0;
          gpio_oe_out[g] <= 1'b0;
        end else if (clk_en_in) begin
          gpio_oe_out[g] <= ~pin_direction_bits_in[g];
          if (pin_level_wr_in && !pin_direction_bits_in[g])
            gpio_out[g] <= pin_level_write_in[g];
        end
      end
    end
  endgenerate

  // readback shows real pin levels and alternate functions
  always @(posedge clock_in) begin
    if (rst_in) begin
      pin_level_bits_out       <= 4'h0;
      pace_input_out           <= 1'b0;
      respiration_blanking_out <= 1'b0;
      respiration_signal_out   <= 1'b0;
      respiration_phase_out    <= 1'b0;
    end else if (clk_en_in) begin
      pin_level_bits_out       <= pin_s2_reg;
      pace_input_out           <= pin_s2_reg[0];
      respiration_blanking_out <= pin_s2_reg[1];
      respiration_signal_out   <= pin_s2_reg[2];
      respiration_phase_out    <= pin_s2_reg[3];
    end
  end
endmodule // adc_serial_readout_port

// ==== host_master_model.sv ====
// host serial master: select, clock and data towards the port
module host_master_model (
  input  wire  clk_in,
  input  wire  dout_in,
  input  wire  dout_oe_in,
  output logic chip_select_n_out,
  output logic sclk_out,
  output logic din_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [159:0] rx;             // captured bits, newest at bit 0
  logic         last_q = 1'b0;  // last driven level of the data line
  // a released line must not look like held data
  wire          line = dout_oe_in ? dout_in : ~last_q;
  always @(dout_in or dout_oe_in) if (dout_oe_in) last_q = dout_in;
  initial begin
    chip_select_n_out = 1'b1;
    sclk_out = 1'b0;  // clock stands low outside frames
    din_out = 1'b0;
  end
  task sel();
    chip_select_n_out = 1'b0;
    rx = '0;
    #100;
  endtask
  // at least eight conversion clocks before deselect
  task desel();
    #100;
    chip_select_n_out = 1'b1;
    #100;
  endtask
  // whole counts only, 125 ns period
  task xfer(input int n, input logic [7:0] tx);
    // start just after a falling conversion-clock edge, so that no
    // link edge ever lands on the rising edge that samples it
    @(negedge clk_in);
    #1;
    for (int i = 0; i < n; i++) begin
      sclk_out = 1'b1;
      din_out = (i < 8) ? tx[7-i] : 1'b0;
      #62.5;
      rx = {rx[158:0], line};
      sclk_out = 1'b0;
      #62.5;
    end
    din_out = 1'b0;
  endtask
endmodule // host_master_model

// ==== tb_adc_serial_readout_port.sv ====
// self-checking bench for the serial readout port
module tb_adc_serial_readout_port;
  timeunit 1ns;
  timeprecision 100ps;
  logic         clock_in = 1'b0;
  logic         rst_in = 1'b1;
  logic         conv = 1'b0, rdc = 1'b0, once = 1'b0, chain = 1'b0, lwr = 1'b0, en = 1'b1;
  logic [127:0] chan = '0;
  logic [7:0]   pwr = 8'hF7, pos = 8'h5A, neg = 8'hC3;  // channel four off
  logic [3:0]   dir = 4'hF, lvl = 4'h0, pad = 4'h9;
  wire          cs_n, sclk, din, dout, oe, rdy_n, ovf, cvalid, pace, blank, rsig, phase;
  wire  [3:0]   gout, goe, lbits;
  wire  [7:0]   cbyte;
  wire  [3:0]   pin = (goe & gout) | (~goe & pad);  // level seen by everyone
  int           failures = 0, n_tests = 0;
  int           n_cmd = 0;  // byte strobes seen
  adc_serial_readout_port dut (.clock_in(clock_in), .rst_in(rst_in), .clk_en_in(en),
    .chip_select_n_in(cs_n), .sclk_in(sclk), .din_in(din), .dout_out(dout), .dout_oe_out(oe),
    .data_ready_n_out(rdy_n), .conv_done_in(conv), .chan_data_in(chan), .chan_powered_in(pwr),
    .lead_off_pos_status_in(pos), .lead_off_neg_status_in(neg), .read_continuous_cmd_in(rdc),
    .read_once_in(once), .chain_enable_in(chain), .pin_direction_bits_in(dir),
    .pin_level_write_in(lvl), .pin_level_wr_in(lwr), .pin_level_bits_out(lbits), .gpio_pin_in(pin),
    .gpio_out(gout), .gpio_oe_out(goe), .pace_input_out(pace), .respiration_blanking_out(blank),
    .respiration_signal_out(rsig), .respiration_phase_out(phase), .frame_overflow_out(ovf),
    .cmd_byte_out(cbyte), .cmd_valid_out(cvalid));
  host_master_model host (.clk_in(clock_in), .dout_in(dout), .dout_oe_in(oe), .chip_select_n_out(cs_n),
    .sclk_out(sclk), .din_out(din));
  initial forever #5 clock_in = ~clock_in;
  // count byte strobes at the edge after they are launched
  always @(posedge clock_in) if (cvalid === 1'b1) n_cmd <= n_cmd + 1;
  task stop_test();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task check(input string nm, input logic [159:0] seen, input logic [159:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // expected frame: pattern, lead-off, pins, words with zeros for off channels
  function automatic logic [151:0] frame(input logic [127:0] d);
    logic [151:0] f;
    f = {4'hC, pos, neg, pin, 128'h0};
    for (int i = 0; i < 8; i++) if (pwr[i]) f[127-16*i -: 16] = d[127-16*i -: 16];
    return f;
  endfunction
  // conversions are assumed started before any read
  task conv_pulse(input logic [127:0] d);
    @(negedge clock_in) chan = d;
    conv = 1'b1;
    @(negedge clock_in) conv = 1'b0;
    repeat (3) @(negedge clock_in);
  endtask
  task arm();
    @(negedge clock_in) once = 1'b1;
    @(negedge clock_in) once = 1'b0;
    #100;
  endtask
  task t_cont();
    logic [151:0] f;
    rdc = 1'b1;
    conv_pulse(128'h8000_7FFF_0001_1234_FFFF_0000_ABCD_4321);
    f = frame(chan);
    check("ready_low", rdy_n, 1'b0);
    host.sel();
    check("new_flag", host.line, 1'b0);
    host.xfer(1, 8'h00);
    #200 check("ready_clr", rdy_n, 1'b1);
    host.xfer(151, 8'h00);
    check("frame", host.rx[151:0], f);
    host.desel();
    check("hiz", oe, 1'b0);
    $display("test cont done");
  endtask
  task t_chain();
    logic [151:0] f;
    @(negedge clock_in) chain = 1'b1;
    conv_pulse(128'h0123_4567_89AB_CDEF_FEDC_BA98_7654_3210);
    f = frame(chan);
    host.sel();
    host.xfer(160, 8'h00);
    check("repeat", host.rx, {f, f[151:144]});
    host.desel();
    @(negedge clock_in) chain = 1'b0;
    $display("test chain done");
  endtask
  task t_once();
    logic [151:0] f, g;
    @(negedge clock_in) rdc = 1'b0;
    conv_pulse(128'hAAAA_5555_1357_2468_8421_C3C3_0F0F_7E7E);
    f = frame(chan);
    host.sel();
    check("idle_one", host.line, 1'b1);
    arm();
    host.xfer(40, 8'h00);
    conv_pulse(128'h1111_2222_3333_4444_5555_6666_7777_8888);
    g = frame(chan);
    host.xfer(112, 8'h00);
    check("held", host.rx[151:0], f);
    host.desel();
    host.sel();
    arm();
    host.xfer(152, 8'h00);
    check("second", host.rx[151:0], g);
    host.desel();
    $display("test once done");
  endtask
  task t_cmd();
    int n0;
    host.sel();
    n0 = n_cmd;
    host.xfer(8, 8'hA5);
    #200 check("cmd", cbyte, 8'hA5);
    check("cmd_strobe", n_cmd - n0, 1);
    host.desel();
    $display("test cmd done");
  endtask
  // pins 0 and 1 to outputs; the write to the input pins must not stick
  task t_gpio();
    @(negedge clock_in) dir = 4'hC;
    lvl = 4'hF;
    lwr = 1'b1;
    @(negedge clock_in) lwr = 1'b0;
    pad = 4'h4;
    repeat (6) @(negedge clock_in);
    check("oe", goe, 4'h3);
    check("drive", gout, 4'h3);
    check("levels", lbits, 4'h7);
    check("alt", {phase, rsig, blank, pace}, 4'h7);
    dir = 4'hF;
    pad = 4'h9;
    repeat (6) @(negedge clock_in);
    $display("test gpio done");
  endtask
  // clock enable low: a conversion pulse must not reach the ready pin
  task t_freeze();
    @(negedge clock_in) en = 1'b0;
    conv_pulse(128'h0);
    check("frozen", rdy_n, 1'b1);
    @(negedge clock_in) en = 1'b1;
    $display("test freeze done");
  endtask
  // fill with the host stalled, then drain all eight in one selection;
  // the ninth frame overflows; a later selection finds none left
  task t_fifo();
    @(negedge clock_in) rdc = 1'b1;
    repeat (9) conv_pulse(128'h0);
    check("full", ovf, 1'b1);
    host.sel();
    check("ovf_clr", ovf, 1'b0);
    for (int i = 0; i < 8; i++) begin
      host.xfer(152, 8'h00);
      check("drain", host.rx[151:0], frame(128'h0));
    end
    host.desel();
    host.sel();
    check("empty", host.line, 1'b1);
    host.desel();
    $display("test fifo done");
  endtask
  initial begin
    repeat (4) @(posedge clock_in);
    @(negedge clock_in) rst_in = 1'b0;
    repeat (2) @(negedge clock_in);
    check("ready_rst", rdy_n, 1'b1);
    check("pins_in", goe, 4'h0);
    t_cont();
    t_chain();
    t_once();
    t_cmd();
    t_gpio();
    t_freeze();
    t_fifo();
    stop_test();
  end
  // run needs about 25k cycles
  initial begin
    #500_000;
    failures++;
    stop_test();
  end
endmodule // tb_adc_serial_readout_port
bind adc_serial_readout_port adc_readout_monitor mon (.clock_in(clock_in), .rst_in(rst_in),
  .clk_en_in(clk_en_in), .chip_select_n_in(chip_select_n_in), .sclk_in(sclk_in),
  .conv_done_in(conv_done_in), .data_ready_n_out(data_ready_n_out), .dout_oe_out(dout_oe_out),
  .pin_direction_bits_in(pin_direction_bits_in), .pin_level_write_in(pin_level_write_in),
  .pin_level_wr_in(pin_level_wr_in), .gpio_pin_in(gpio_pin_in), .gpio_out(gpio_out),
  .gpio_oe_out(gpio_oe_out), .pin_level_bits_out(pin_level_bits_out),
  .frame_overflow_out(frame_overflow_out), .cmd_valid_out(cmd_valid_out));
